// ==== interval_timer.sv ====
// Purpose: cycle counter that pulses when a run lasts len cycles
// Assumes: len_i at least 1
// Notes: restarts after each pulse, so a long run pulses periodically
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // control
   input wire logic run_i,
   input wire logic clear_i,
   input wire logic [W-1:0] len_i,
   // result
   output logic done_o
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   wire last = (cnt_r == len_i - W'(1));

   assign done_o = run_i & ~clear_i & last;
   assign cnt_nxt = (clear_i | ~run_i | last) ? '0 : cnt_r + W'(1);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// ==== lnb_diag_pkg.sv ====
// Purpose: types shared by the diagnostic block
// Assumes: nothing
// Notes: control byte is {reserved[3:0], comp, vsel[2:0]}
package lnb_diag_pkg;

   typedef struct packed {
      logic [3:0] rsvd;
      logic comp;
      logic [2:0] vsel;
   } ctrl_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic power_not_good_flag;
      logic sink_overcurrent_flag;
      logic output_low_flag;
      logic overtemp_flag;
      logic overload_flag;
   } status_t;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b000,
      BUS_ADDR = 3'b001,
      BUS_ADDR_ACK = 3'b010,
      BUS_WRITE = 3'b011,
      BUS_WRITE_ACK = 3'b100,
      BUS_READ = 3'b101,
      BUS_READ_ACK = 3'b110
   } bus_state_t;

   typedef enum logic [1:0] {
      OL_NORMAL = 2'b00,
      OL_ON = 2'b01,
      OL_OFF = 2'b10
   } ol_state_t;

endpackage

// ==== lnb_diag_props.sv ====
// Purpose: port properties of the supply diagnostic block
// Assumes: inputs act within 3 clocks; interval counts set small
// Notes: bound to the block after the module
`timescale 1ns/1ps
`default_nettype none
module lnb_diag_props #(
   parameter logic [31:0] TON_CYC = 32'h14,
   parameter logic [31:0] TOFF_CYC = 32'h32,
   parameter logic [31:0] SINK_TMO_CYC = 32'h0A
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic addr_sel_i,
   // detectors
   input wire logic uvlo_i,
   input wire logic low_supply_detect_i,
   input wire logic overtemp_i,
   input wire logic overload_i,
   input wire logic vout_below_i,
   input wire logic sink_oc_i,
   // block outputs
   input wire lnb_diag_pkg::ctrl_t ctrl_o,
   input wire logic boost_en_o,
   input wire logic regulator_en_o,
   input wire lnb_diag_pkg::status_t status_o
);
   import lnb_diag_pkg::*;
   // ----------
   // properties
   // ----------
   // windows of 5 to 8 cycles cover the two-flop sync plus one register
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   AST_CTRL_SPARE: assert property (ctrl_o.rsvd == 4'h0)
      else $error("control spare bits set");
   AST_STATUS_SPARE: assert property (status_o.rsvd == 3'h0)
      else $error("status spare bits set");
   AST_SDA_DRIVE_LOW: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   AST_LOCK_CLEAR: assert property (uvlo_i [*5] |-> ctrl_o == 8'h00)
      else $error("control kept in lockout");
   AST_LOCK_SILENT: assert property (uvlo_i [*6] |-> !sda_oe_o)
      else $error("bus answered in lockout");
   AST_HOT_OFF: assert property (overtemp_i [*5] |-> !boost_en_o && !regulator_en_o)
      else $error("power on while hot");
   AST_HOT_FLAG: assert property (overtemp_i [*6] |-> status_o.overtemp_flag)
      else $error("hot flag missing");
   AST_SUPPLY_FLAG: assert property (low_supply_detect_i [*6] |-> status_o.power_not_good_flag)
      else $error("supply flag missing");
   AST_OUT_LOW: assert property ((vout_below_i && ctrl_o.vsel != 3'h0) [*6] |-> status_o.output_low_flag)
      else $error("output low flag missing");
   AST_OUT_OK: assert property ((!vout_below_i) [*6] |-> !status_o.output_low_flag)
      else $error("output low flag stuck");
   AST_SINK_WAIT: assert property ((!sink_oc_i) [*6] ##1 sink_oc_i |-> (!status_o.sink_overcurrent_flag) [*8])
      else $error("sink flag too early");
   AST_OL_SHUT: assert property ($rose(status_o.overload_flag) |-> ##[0:1] !regulator_en_o)
      else $error("overload flag without shutdown");
   AST_CTRL_IDLE: assert property ((scl_i && sda_i && !uvlo_i) [*8] |=> $stable(ctrl_o))
      else $error("control moved on idle bus");
   COV_ACK: cover property ($rose(sda_oe_o));
   COV_OL: cover property ($rose(status_o.overload_flag));
   COV_HOT: cover property (overtemp_i && !regulator_en_o);
endmodule
bind lnb_supply_diag_protection lnb_diag_props #(.TON_CYC(TON_CYC), .TOFF_CYC(TOFF_CYC),
   .SINK_TMO_CYC(SINK_TMO_CYC)) props (.*);
`default_nettype wire

// ==== lnb_diag_regs.svh ====
// Purpose: constants for the supply diagnostic and protection block
// Assumes: 200 MHz core clock
// Notes: interval timings, control reset value and bus addresses live here
`ifndef LNB_DIAG_REGS_SVH
`define LNB_DIAG_REGS_SVH

`define CLK_KHZ 200000
`define TON_MS 90
`define TOFF_MS 900
`define SINK_TMO_MS 10
`define TON_CYC (`TON_MS * `CLK_KHZ)
`define TOFF_CYC (`TOFF_MS * `CLK_KHZ)
`define SINK_TMO_CYC (`SINK_TMO_MS * `CLK_KHZ)

`define CTRL_RESET 8'h00
`define ADDR_LO 7'h08
`define ADDR_HI 7'h09

`endif

// ==== lnb_host_model.sv ====
// Purpose: bus host model for the supply diagnostic block
// Assumes: data line pulled up outside the model; the model drives the clock line itself
// Notes: half bit is 8 core clocks, wide against the 3-clock sync
`timescale 1ns/1ps
`default_nettype none
module lnb_host_model (
   // clock
   input wire logic clk_i,
   // bus
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // ------------
   // bus sequence
   // ------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // data moves only while the clock line is low
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o <= ~b;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      r = sda_i;
      tick(4);
      scl_o <= 1'b0;
      tick(4);
   endtask
   // ninth bit is always released: device ack on writes, host nack on reads
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic nak;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(1'b1, nak);
      ack = ~nak;
   endtask
   task automatic xfer(input logic [6:0] a, input logic rnw, input logic [7:0] tx,
                       output logic ack_a, output logic ack_d, output logic [7:0] rx);
      logic [7:0] unused;
      sda_pull_o <= 1'b1;
      tick(8);
      scl_o <= 1'b0;
      tick(4);
      byte_io({a, rnw}, unused, ack_a);
      rx = 8'hFF;
      ack_d = 1'b0;
      if (ack_a) begin
         byte_io(tx, rx, ack_d);
      end
      sda_pull_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(8);
      sda_pull_o <= 1'b0;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ==== lnb_supply_diag_protection.sv ====
// Purpose: host control byte, latched and live diagnostics, protection sequencing
// Assumes: analog detectors arrive as asynchronous levels
// Notes: serial bus slave is built in; one control and one status byte
`timescale 1ns/1ps
`default_nettype none
`include "lnb_diag_regs.svh"
module lnb_supply_diag_protection #(
   parameter logic [31:0] TON_CYC = `TON_CYC,
   parameter logic [31:0] TOFF_CYC = `TOFF_CYC,
   parameter logic [31:0] SINK_TMO_CYC = `SINK_TMO_CYC,
   parameter logic [6:0] ADDR_LO = `ADDR_LO,
   parameter logic [6:0] ADDR_HI = `ADDR_HI
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_sel_i,
   // analog detectors
   input wire logic uvlo_i,
   input wire logic low_supply_detect_i,
   input wire logic overtemp_i,
   input wire logic overload_i,
   input wire logic vout_below_i,
   input wire logic sink_oc_i,
   // power controls
   output lnb_diag_pkg::ctrl_t ctrl_o,
   output logic boost_en_o,
   output logic regulator_en_o,
   // diagnostics
   output lnb_diag_pkg::status_t status_o
);
   import lnb_diag_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   wire [NSYNC-1:0] raw = {scl_i, sda_i, addr_sel_i, uvlo_i, low_supply_detect_i,
                           overtemp_i, overload_i, vout_below_i, sink_oc_i};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // bus lines reset to their idle high level, so no false edge follows reset
         meta_r <= 9'h180;
         sync_r <= 9'h180;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end

   wire scl_s = sync_r[8];
   wire sda_s = sync_r[7];
   wire addr_sel_s = sync_r[6];
   wire uvlo_s = sync_r[5];
   wire lsd_s = sync_r[4];
   wire hot_s = sync_r[3];
   wire ol_s = sync_r[2];
   wire vlow_s = sync_r[1];
   wire sink_s = sync_r[0];

   // ----------------------------------------
   // bus condition detection
   // ----------------------------------------
   logic scl_d_r;
   logic sda_d_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ----------------------------------------
   // serial slave state
   // ----------------------------------------
   bus_state_t bus_r;
   bus_state_t bus_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic rw_r;
   logic rw_nxt;
   logic ack_r;
   logic ack_nxt;
   logic oe_r;
   logic oe_nxt;
   logic wr_stb;
   logic rd_done;
   ctrl_t ctrl_r;
   status_t status_r;

   // two selectable addresses
   wire [6:0] my_addr = addr_sel_s ? ADDR_HI : ADDR_LO;
   wire addr_hit = (shift_r[7:1] == my_addr);

   always_comb begin
      bus_nxt = bus_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      bit_nxt = bit_r;
      rw_nxt = rw_r;
      ack_nxt = ack_r;
      oe_nxt = oe_r;
      wr_stb = 1'b0;
      rd_done = 1'b0;
      if (uvlo_s) begin
         // lockout: slave stays deaf and releases the line
         bus_nxt = BUS_IDLE;
         oe_nxt = 1'b0;
      end else if (stop_cond) begin
         bus_nxt = BUS_IDLE;
         oe_nxt = 1'b0;
      end else if (start_cond) begin
         bus_nxt = BUS_ADDR;
         bit_nxt = 4'h0;
         oe_nxt = 1'b0;
      end else if (scl_rise) begin
         case (bus_r)
            BUS_ADDR, BUS_WRITE: begin
               shift_nxt = {shift_r[6:0], sda_s};
               bit_nxt = bit_r + 4'h1;
            end
            BUS_READ: begin
               bit_nxt = bit_r + 4'h1;
            end
            BUS_READ_ACK: begin
               ack_nxt = ~sda_s;
            end
            default: begin
               bit_nxt = bit_r;
            end
         endcase
      end else if (scl_fall) begin
         case (bus_r)
            BUS_ADDR: begin
               if (bit_r == 4'h8) begin
                  if (addr_hit) begin
                     bus_nxt = BUS_ADDR_ACK;
                     rw_nxt = shift_r[0];
                     oe_nxt = 1'b1;
                  end else begin
                     bus_nxt = BUS_IDLE;
                  end
               end
            end
            BUS_ADDR_ACK: begin
               bit_nxt = 4'h0;
               if (rw_r) begin
                  bus_nxt = BUS_READ;
                  tx_nxt = status_r;
                  oe_nxt = ~status_r[7];
               end else begin
                  bus_nxt = BUS_WRITE;
                  oe_nxt = 1'b0;
               end
            end
            BUS_WRITE: begin
               if (bit_r == 4'h8) begin
                  bus_nxt = BUS_WRITE_ACK;
                  wr_stb = 1'b1;
                  oe_nxt = 1'b1;
               end
            end
            BUS_WRITE_ACK: begin
               bus_nxt = BUS_WRITE;
               bit_nxt = 4'h0;
               oe_nxt = 1'b0;
            end
            BUS_READ: begin
               if (bit_r == 4'h8) begin
                  bus_nxt = BUS_READ_ACK;
                  oe_nxt = 1'b0;
                  rd_done = 1'b1;
               end else begin
                  tx_nxt = {tx_r[6:0], 1'b0};
                  oe_nxt = ~tx_r[6];
               end
            end
            BUS_READ_ACK: begin
               bit_nxt = 4'h0;
               if (ack_r) begin
                  // repeated reads return a fresh snapshot
                  bus_nxt = BUS_READ;
                  tx_nxt = status_r;
                  oe_nxt = ~status_r[7];
               end else begin
                  bus_nxt = BUS_IDLE;
               end
            end
            default: begin
               bus_nxt = BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_r <= BUS_IDLE;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         bit_r <= 4'h0;
         rw_r <= 1'b0;
         ack_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         bus_r <= bus_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         bit_r <= bit_nxt;
         rw_r <= rw_nxt;
         ack_r <= ack_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = oe_r;

   // ----------------------------------------
   // control byte
   // ----------------------------------------
   ctrl_t ctrl_nxt;

   // lockout wins over a write landing in the same cycle
   assign ctrl_nxt = uvlo_s ? ctrl_t'(`CTRL_RESET) :
                     wr_stb ? ctrl_t'({4'h0, shift_r[3:0]}) : ctrl_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r <= ctrl_t'(`CTRL_RESET);
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl_o = ctrl_r;
   // voltage code zero keeps the output off
   wire out_on = (ctrl_r.vsel != 3'b000);

   // ----------------------------------------
   // overload on/off sequencing
   // ----------------------------------------
   ol_state_t ol_r;
   ol_state_t ol_nxt;
   logic ol_seen_r;
   logic ol_seen_nxt;
   logic ol_tick;
   logic ol_set;
   wire ol_timing = (ol_r != OL_NORMAL);
   wire ol_restart = (ol_nxt != ol_r);
   wire [31:0] ol_len = (ol_r == OL_OFF) ? TOFF_CYC : TON_CYC;

   interval_timer #(.W(32)) u_ol_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .run_i(ol_timing),
      .clear_i(1'b0),
      .len_i(ol_len),
      .done_o(ol_tick)
   );

   always_comb begin
      ol_nxt = ol_r;
      ol_seen_nxt = ol_seen_r | ol_s;
      ol_set = 1'b0;
      case (ol_r)
         OL_NORMAL: begin
            ol_seen_nxt = 1'b0;
            if (ol_s & out_on) begin
               ol_nxt = OL_ON;
            end
         end
         OL_ON: begin
            if (ol_tick) begin
               if (ol_seen_r | ol_s) begin
                  ol_nxt = OL_OFF;
                  ol_set = 1'b1;
               end else begin
                  ol_nxt = OL_NORMAL;
               end
            end
         end
         OL_OFF: begin
            // detector is blind while off; judge only the next on-interval
            ol_seen_nxt = 1'b0;
            if (ol_tick) begin
               ol_nxt = OL_ON;
            end
         end
         default: begin
            ol_nxt = OL_NORMAL;
         end
      endcase
      if (!out_on) begin
         ol_nxt = OL_NORMAL;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ol_r <= OL_NORMAL;
         ol_seen_r <= 1'b0;
      end else begin
         ol_r <= ol_nxt;
         ol_seen_r <= ol_restart ? 1'b0 : ol_seen_nxt;
      end
   end

   // ----------------------------------------
   // sink overcurrent persistence
   // ----------------------------------------
   logic sink_tick;
   logic sink_flag_r;

   interval_timer #(.W(32)) u_sink_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .run_i(sink_s),
      .clear_i(1'b0),
      .len_i(SINK_TMO_CYC),
      .done_o(sink_tick)
   );

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sink_flag_r <= 1'b0;
      end else begin
         sink_flag_r <= sink_s & (sink_flag_r | sink_tick);
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   function automatic logic latch_flag(input logic cur, input logic set, input logic cause,
                                       input logic rd);
      // set beats clear; read clears only once the cause is gone
      latch_flag = set | (cur & ~(rd & ~cause));
   endfunction

   status_t status_nxt;
   wire ol_cause = ol_timing;

   always_comb begin
      status_nxt = '0;
      status_nxt.overload_flag = latch_flag(status_r.overload_flag, ol_set,
                                            ol_cause, rd_done);
      status_nxt.overtemp_flag = latch_flag(status_r.overtemp_flag, hot_s,
                                            hot_s, rd_done);
      status_nxt.power_not_good_flag = latch_flag(status_r.power_not_good_flag, lsd_s,
                                                  lsd_s, rd_done);
      status_nxt.output_low_flag = out_on & vlow_s;
      status_nxt.sink_overcurrent_flag = sink_flag_r;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign status_o = status_r;

   // ----------------------------------------
   // power block enables
   // ----------------------------------------
   logic boost_en_r;
   logic reg_en_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boost_en_r <= 1'b0;
         reg_en_r <= 1'b0;
      end else begin
         boost_en_r <= out_on & ~hot_s;
         reg_en_r <= out_on & ~hot_s & (ol_nxt != OL_OFF);
      end
   end

   assign boost_en_o = boost_en_r;
   assign regulator_en_o = reg_en_r;

endmodule
`default_nettype wire

// ==== lnb_supply_diag_protection_tb.sv ====
// Purpose: self-checking bench for the supply diagnostic block
// Assumes: short interval counts, host model on the bus
// Notes: one line per finished test, counts before the verdict
`timescale 1ns/1ps
`default_nettype none
module lnb_supply_diag_protection_tb;
   import lnb_diag_pkg::*;
   localparam logic [6:0] ALO = 7'h08;
   localparam logic [6:0] AHI = 7'h09;
   logic clk_i;
   logic arst_n;
   logic asel, uvlo, lsd, hot, ovl, vlow, sink;
   logic scl, pull, sda, sda_oe, boost_en, reg_en;
   ctrl_t ctrl;
   status_t status;
   int fail_count = 0;
   int checked = 0;
   assign sda = ~(sda_oe | pull);
   // on 20, off 50, sink wait 10 cycles
   lnb_supply_diag_protection #(.TON_CYC(32'h14), .TOFF_CYC(32'h32), .SINK_TMO_CYC(32'h0A),
      .ADDR_LO(ALO), .ADDR_HI(AHI)) dut (
      .clk_i(clk_i), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .addr_sel_i(asel), .uvlo_i(uvlo), .low_supply_detect_i(lsd), .overtemp_i(hot), .overload_i(ovl),
      .vout_below_i(vlow), .sink_oc_i(sink), .ctrl_o(ctrl), .boost_en_o(boost_en),
      .regulator_en_o(reg_en), .status_o(status));
   lnb_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // -----
   // tasks
   // -----
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic ok);
      logic aa, ad;
      logic [7:0] rx;
      host.xfer(a, 1'b0, v, aa, ad, rx);
      chk("write ack", {6'h00, ok, ok}, {6'h00, aa, ad});
   endtask
   task automatic rd(input logic [7:0] exp);
      logic aa, ad;
      logic [7:0] v;
      host.xfer(ALO, 1'b1, 8'hFF, aa, ad, v);
      chk("read ack", 8'h01, 8'(aa));
      chk("status read", exp, v);
   endtask
   task automatic end_sim;
      $display("%0d checks, %0d mismatches", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      tick(40000);
      fail_count++;
      end_sim();
   end
   // -----
   // tests
   // -----
   initial begin
      arst_n = 1'b0;
      {asel, uvlo, lsd, hot, ovl, vlow, sink} = 7'h00;
      tick(3);
      arst_n <= 1'b1;
      tick(4);
      chk("ctrl", 8'h00, ctrl);
      rd(8'h00);
      $display("test reset done");
      // upper nibble is spare and must not stick
      for (int i = 0; i < 16; i++) begin
         wr(ALO, 8'hF0 | 8'(i), 1'b1);
         chk("ctrl", 8'(i), ctrl);
      end
      $display("test control codes done");
      asel <= 1'b1;
      tick(4);
      wr(ALO, 8'h03, 1'b0);
      chk("ctrl", 8'h0F, ctrl);
      wr(AHI, 8'h03, 1'b1);
      chk("ctrl", 8'h03, ctrl);
      asel <= 1'b0;
      $display("test address select done");
      uvlo <= 1'b1;
      tick(6);
      chk("ctrl", 8'h00, ctrl);
      wr(ALO, 8'h05, 1'b0);
      chk("ctrl", 8'h00, ctrl);
      uvlo <= 1'b0;
      tick(4);
      wr(ALO, 8'h05, 1'b1);
      chk("ctrl", 8'h05, ctrl);
      $display("test lockout done");
      vlow <= 1'b1;
      tick(6);
      rd(8'h04);
      vlow <= 1'b0;
      tick(6);
      rd(8'h00);
      sink <= 1'b1;
      tick(6);
      chk("sink early", 8'h00, status);
      tick(20);
      chk("sink flag", 8'h08, status);
      sink <= 1'b0;
      tick(6);
      chk("status", 8'h00, status);
      $display("test live flags done");
      hot <= 1'b1;
      tick(6);
      chk("enables", 8'h00, {6'h00, boost_en, reg_en});
      rd(8'h02);
      hot <= 1'b0;
      tick(6);
      chk("enables", 8'h03, {6'h00, boost_en, reg_en});
      rd(8'h02);
      rd(8'h00);
      lsd <= 1'b1;
      tick(6);
      chk("status", 8'h10, status);
      lsd <= 1'b0;
      tick(6);
      rd(8'h10);
      rd(8'h00);
      $display("test latched flags done");
      ovl <= 1'b1;
      tick(20);
      chk("regulator", 8'h01, 8'(reg_en));
      tick(20);
      chk("regulator", 8'h00, 8'(reg_en));
      chk("status", 8'h01, status);
      tick(44);
      chk("regulator", 8'h01, 8'(reg_en));
      tick(26);
      chk("regulator", 8'h00, 8'(reg_en));
      ovl <= 1'b0;
      tick(90);
      chk("regulator", 8'h01, 8'(reg_en));
      rd(8'h01);
      rd(8'h00);
      $display("test overload done");
      end_sim();
   end
endmodule
`default_nettype wire
